// ==== include/dmas_consts.svh ====
// dma event status block: register offsets, field positions, reset values.
// assumes inclusion by bare name from design files; definitions only.
`ifndef DMAS_CONSTS_SVH
`define DMAS_CONSTS_SVH

// axi4-lite address width and register byte offsets
`define DMAS_ADDR_W 8
`define DMAS_OFS_STATUS 8'h00
`define DMAS_OFS_CLEAR 8'h04
`define DMAS_OFS_ENABLE 8'h08

// channels held here and flag slots per channel
`define DMAS_CH_LO 2
`define DMAS_CH_HI 4
`define DMAS_BITS_PER_CH 4

// field position inside one channel nibble
`define DMAS_FLD_ANY 0
`define DMAS_FLD_DONE 1
`define DMAS_FLD_HALF 2
`define DMAS_FLD_ERR 3

// reset values
`define DMAS_RST_STATUS 32'h0000_0000
`define DMAS_RST_ENABLE 32'h0000_0000
`define DMAS_RST_FLAGS 4'h0

`endif

// ==== include/dmas_pkg.sv ====
// dma event status block: shared types.
// assumes dmas_consts.svh is on the include path.
package dmas_pkg;

    // one-cycle event strobes of one channel from the dma engine
    typedef struct packed {
        logic error;
        logic half;
        logic done;
    } dmas_evt_s;

    // flags of one channel, bit 0 is the any-event flag
    typedef struct packed {
        logic error;
        logic half;
        logic done;
        logic any;
    } dmas_flags_s;

    // axi4-lite response codes
    typedef enum logic [1:0] {
        DMAS_OKAY = 2'b00,
        DMAS_SLVERR = 2'b10,
        DMAS_DECERR = 2'b11
    } dmas_resp_e;

endpackage

// ==== hdl/dmas_flag_cell.sv ====
// dma event status block: sticky flags of one channel.
// assumes events and clears come from logic on the same clock.
`include "dmas_consts.svh"

module dmas_flag_cell
    import dmas_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // events and write-one-to-clear nibble
    input wire dmas_evt_s evt,
    input wire logic [3:0] clr,
    // stored flags
    output dmas_flags_s flags
);

    wire logic [3:0] set_w;
    wire logic [3:0] clr_eff_w;
    wire logic [3:0] flags_nxt;

    // any-event flag follows every event of the channel
    assign set_w = {evt.error, evt.half, evt.done, evt.error | evt.half | evt.done};
    // global clear wipes all four flags together
    assign clr_eff_w = clr | {4{clr[`DMAS_FLD_ANY]}};
    // set after clear so a coinciding event survives
    assign flags_nxt = (flags & ~clr_eff_w) | set_w;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags <= `DMAS_RST_FLAGS;
        end else begin
            flags <= flags_nxt;
        end
    end

endmodule

// ==== hdl/dmas_status_top.sv ====
// dma event status block: flags of channels 2..4, axi4-lite slave, interrupt.
// assumes event strobes come from the dma engine on clk, one cycle each.
//
// Summary of operation
// - channel 2 half-transfer flag, bit 10, set by hardware, read-only.
// - channel 2 transfer-error flag, bit 11, set by hardware on error.
// - channel 3 any-event flag, bit 12, set on any event, else zero.
// - channel 3 transfer-complete flag, bit 13, set when transfer finishes.
// - channel 3 half flag at bit 14, error flag at bit 15.
// - channel 4 any, done, half, error flags at bits 16 to 19.
// - a flag stays set until software writes one to its clear bit.
// - all event flags are zero after reset.
// - writing one to a channel's global clear bit clears its four flags.
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`include "dmas_consts.svh"

module dmas_status_top
    import dmas_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // event strobes from the dma engine, one per channel
    input wire dmas_evt_s evt_i [`DMAS_CH_HI:`DMAS_CH_LO],
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`DMAS_ADDR_W-1:0] s_axi_awaddr,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [`DMAS_ADDR_W-1:0] s_axi_araddr,
    // axi4-lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // bit positions used by the checks below

    localparam int B_CH2_HALF = 2 * `DMAS_BITS_PER_CH + `DMAS_FLD_HALF;
    localparam int B_CH2_ERR = 2 * `DMAS_BITS_PER_CH + `DMAS_FLD_ERR;
    localparam int B_CH3_ANY = 3 * `DMAS_BITS_PER_CH + `DMAS_FLD_ANY;
    localparam int B_CH3_DONE = 3 * `DMAS_BITS_PER_CH + `DMAS_FLD_DONE;
    localparam int B_CH3_HALF = 3 * `DMAS_BITS_PER_CH + `DMAS_FLD_HALF;
    localparam int B_CH3_ERR = 3 * `DMAS_BITS_PER_CH + `DMAS_FLD_ERR;
    localparam int B_CH4_ANY = 4 * `DMAS_BITS_PER_CH + `DMAS_FLD_ANY;
    localparam int B_CH4_ERR = 4 * `DMAS_BITS_PER_CH + `DMAS_FLD_ERR;
    localparam int B_CH2_ANY = 2 * `DMAS_BITS_PER_CH + `DMAS_FLD_ANY;
    localparam int B_CH4_DONE = 4 * `DMAS_BITS_PER_CH + `DMAS_FLD_DONE;
    localparam int B_CH4_HALF = 4 * `DMAS_BITS_PER_CH + `DMAS_FLD_HALF;

    ////////////////////////////////////////////////////////////////////////////
    // write channel state

    logic aw_full_r;
    logic w_full_r;
    logic [`DMAS_ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic [31:0] en_r;

    wire logic aw_take;
    wire logic w_take;
    wire logic do_wr;
    wire logic aw_full_nxt;
    wire logic w_full_nxt;
    wire logic bvalid_nxt;
    wire logic [31:0] strb_mask;
    wire logic [31:0] wr_bits;
    wire logic wr_status;
    wire logic wr_clear;
    wire logic wr_enable;
    wire logic [31:0] clr_vec;
    wire logic [31:0] en_nxt;
    wire dmas_resp_e bresp_nxt;

    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    // both halves held and no response pending
    assign do_wr = aw_full_r & w_full_r & ~s_axi_bvalid;
    assign aw_full_nxt = aw_full_r ? ~do_wr : aw_take;
    assign w_full_nxt = w_full_r ? ~do_wr : w_take;
    assign bvalid_nxt = do_wr | (s_axi_bvalid & ~s_axi_bready);

    assign strb_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    assign wr_bits = wdata_r & strb_mask;

    assign wr_status = {awaddr_r[`DMAS_ADDR_W-1:2], 2'b00} == `DMAS_OFS_STATUS;
    assign wr_clear = {awaddr_r[`DMAS_ADDR_W-1:2], 2'b00} == `DMAS_OFS_CLEAR;
    assign wr_enable = {awaddr_r[`DMAS_ADDR_W-1:2], 2'b00} == `DMAS_OFS_ENABLE;

    // clear word is a one-cycle pulse, zero bits have no effect
    assign clr_vec = (do_wr & wr_clear) ? wr_bits : 32'h0000_0000;
    assign en_nxt = (do_wr & wr_enable) ? ((en_r & ~strb_mask) | wr_bits) : en_r;
    // status is read-only: write accepted with okay, contents dropped
    assign bresp_nxt = (wr_status | wr_clear | wr_enable) ? DMAS_OKAY : DMAS_DECERR;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= DMAS_OKAY;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            s_axi_awready <= ~aw_full_nxt & ~bvalid_nxt;
            s_axi_wready <= ~w_full_nxt & ~bvalid_nxt;
            s_axi_bvalid <= bvalid_nxt;
            if (do_wr) begin
                s_axi_bresp <= bresp_nxt;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            awaddr_r <= '0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            en_r <= `DMAS_RST_ENABLE;
        end else begin
            if (aw_take) begin
                awaddr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            en_r <= en_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-channel flags

    dmas_flags_s flags_w [`DMAS_CH_HI:`DMAS_CH_LO];
    wire logic [31:0] status_w;

    // bits of channels outside this block read as zero
    assign status_w[`DMAS_CH_LO*`DMAS_BITS_PER_CH-1:0] = '0;
    assign status_w[31:(`DMAS_CH_HI+1)*`DMAS_BITS_PER_CH] = '0;

    genvar ch;
    generate
        for (ch = `DMAS_CH_LO; ch <= `DMAS_CH_HI; ch++) begin : g_ch
            dmas_flag_cell u_cell (
                .clk(clk),
                .sys_rst(sys_rst),
                .evt(evt_i[ch]),
                .clr(clr_vec[ch*`DMAS_BITS_PER_CH +: `DMAS_BITS_PER_CH]),
                .flags(flags_w[ch])
            );
            assign status_w[ch*`DMAS_BITS_PER_CH +: `DMAS_BITS_PER_CH] = flags_w[ch];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // read channel

    wire logic ar_take;
    wire logic rvalid_nxt;
    wire logic [`DMAS_ADDR_W-1:0] rd_word;
    wire logic [31:0] rd_data;
    wire dmas_resp_e rd_resp;

    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign rvalid_nxt = ar_take | (s_axi_rvalid & ~s_axi_rready);
    assign rd_word = {s_axi_araddr[`DMAS_ADDR_W-1:2], 2'b00};
    // clear register is write-only and reads as zero
    assign rd_data = (rd_word == `DMAS_OFS_STATUS) ? status_w :
                     (rd_word == `DMAS_OFS_ENABLE) ? en_r : 32'h0000_0000;
    assign rd_resp = (rd_word == `DMAS_OFS_STATUS || rd_word == `DMAS_OFS_CLEAR ||
                      rd_word == `DMAS_OFS_ENABLE) ? DMAS_OKAY : DMAS_DECERR;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= DMAS_OKAY;
        end else begin
            s_axi_arready <= ~rvalid_nxt;
            s_axi_rvalid <= rvalid_nxt;
            if (ar_take) begin
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_resp;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt: registered, so it trails the flag by one cycle

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_w & en_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    wire logic ch3_ev;
    wire logic [31:0] ev_vec;
    wire logic [31:0] clr_span;

    assign ch3_ev = evt_i[3].done | evt_i[3].half | evt_i[3].error;
    assign ev_vec = {12'h000,
                     evt_i[4].error, evt_i[4].half, evt_i[4].done,
                     evt_i[4].done | evt_i[4].half | evt_i[4].error,
                     evt_i[3].error, evt_i[3].half, evt_i[3].done, ch3_ev,
                     evt_i[2].error, evt_i[2].half, evt_i[2].done,
                     evt_i[2].done | evt_i[2].half | evt_i[2].error,
                     8'h00};
    // a global clear bit reaches all four flags of its channel
    assign clr_span = clr_vec | {12'h000, {4{clr_vec[B_CH4_ANY]}}, {4{clr_vec[B_CH3_ANY]}},
                                 {4{clr_vec[B_CH2_ANY]}}, 8'h00};

    sequence s_glob_clear3;
        do_wr && wr_clear && wstrb_r[1] && wdata_r[B_CH3_ANY] && !ch3_ev;
    endsequence

    sequence s_ch3_cleared;
        !status_w[B_CH3_ANY] && !status_w[B_CH3_DONE] &&
        !status_w[B_CH3_HALF] && !status_w[B_CH3_ERR];
    endsequence

    property p_ch2_half;
        @(posedge clk) disable iff (sys_rst)
        evt_i[2].half |=> status_w[B_CH2_HALF];
    endproperty
    a_ch2_half: assert property (p_ch2_half) else $error("ch2 half flag not set");

    property p_ch2_err;
        @(posedge clk) disable iff (sys_rst)
        evt_i[2].error |=> status_w[B_CH2_ERR] && status_w[B_CH2_ERR - 3];
    endproperty
    a_ch2_err: assert property (p_ch2_err) else $error("ch2 error flag not set");

    property p_ch3_any;
        @(posedge clk) disable iff (sys_rst)
        $rose(status_w[B_CH3_ANY]) |-> $past(ch3_ev);
    endproperty
    a_ch3_any: assert property (p_ch3_any) else $error("ch3 any flag rose with no event");

    property p_ch3_done;
        @(posedge clk) disable iff (sys_rst)
        evt_i[3].done |=> status_w[B_CH3_DONE] && status_w[B_CH3_ANY];
    endproperty
    a_ch3_done: assert property (p_ch3_done) else $error("ch3 done flag not set");

    property p_ch3_half_err;
        @(posedge clk) disable iff (sys_rst)
        (evt_i[3].half || evt_i[3].error) |=>
            (status_w[B_CH3_HALF] == $past(evt_i[3].half) || status_w[B_CH3_HALF]) &&
            (status_w[B_CH3_ERR] || !$past(evt_i[3].error));
    endproperty
    a_ch3_half_err: assert property (p_ch3_half_err) else $error("ch3 half/err flag");

    property p_ch4_flags;
        @(posedge clk) disable iff (sys_rst)
        evt_i[4].error |=> status_w[B_CH4_ERR] && status_w[B_CH4_ANY];
    endproperty
    a_ch4_flags: assert property (p_ch4_flags) else $error("ch4 error/any flag not set");

    property p_sticky;
        @(posedge clk) disable iff (sys_rst)
        ((status_w & ~$past(status_w)) & ~$past(ev_vec)) == 32'h0000_0000 &&
        (($past(status_w) & ~status_w) & ~$past(clr_span)) == 32'h0000_0000;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag changed without cause");

    property p_reset_zero;
        @(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) |-> status_w == `DMAS_RST_STATUS && !irq;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("flags not zero after reset");

    property p_glob_clear;
        @(posedge clk) disable iff (sys_rst)
        s_glob_clear3 |=> s_ch3_cleared;
    endproperty
    a_glob_clear: assert property (p_glob_clear) else $error("global clear missed ch3");

    property p_set_wins;
        @(posedge clk) disable iff (sys_rst)
        ((ev_vec & clr_vec) != 32'h0000_0000) |=>
            (status_w & $past(ev_vec & clr_vec)) == $past(ev_vec & clr_vec);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

    property p_status_ro;
        @(posedge clk) disable iff (sys_rst)
        (do_wr && wr_status && ev_vec == 32'h0000_0000) |=> $stable(status_w);
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status write changed flags");

    property p_irq;
        @(posedge clk) disable iff (sys_rst)
        (|(status_w & en_r)) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing for enabled flag");

    property p_bresp_follows;
        @(posedge clk) disable iff (sys_rst)
        do_wr |=> s_axi_bvalid;
    endproperty
    a_bresp_follows: assert property (p_bresp_follows) else $error("write response missing");

    property p_bvalid_hold;
        @(posedge clk) disable iff (sys_rst)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");

    property p_rvalid_hold;
        @(posedge clk) disable iff (sys_rst)
        (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped");

    property p_ch4_done;
        @(posedge clk) disable iff (sys_rst)
        evt_i[4].done |=> status_w[B_CH4_DONE] && status_w[B_CH4_ANY];
    endproperty
    a_ch4_done: assert property (p_ch4_done) else $error("ch4 done flag not set");

    property p_ch4_half;
        @(posedge clk) disable iff (sys_rst)
        evt_i[4].half |=> status_w[B_CH4_HALF] && status_w[B_CH4_ANY];
    endproperty
    a_ch4_half: assert property (p_ch4_half) else $error("ch4 half flag not set");

    property p_irq_quiet;
        @(posedge clk) disable iff (sys_rst)
        !(|(status_w & en_r)) |=> !irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq with no enabled flag");

endmodule

// ==== tb/tb_dma_channel_status_flags.sv ====
// testbench for the dma event status block: axi4-lite tasks and event pulses.
// assumes dmas_pkg is compiled first and dmas_consts.svh is on the include path.
`include "dmas_consts.svh"

module tb_dma_channel_status_flags
    import dmas_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////////
    logic clk;
    logic sys_rst;
    dmas_evt_s evt [`DMAS_CH_HI:`DMAS_CH_LO];
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    int error_cnt;
    int n_checks;

    dmas_status_top u_dut (
        .clk(clk), .sys_rst(sys_rst), .evt_i(evt),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // inj: event strobes that land at the same edge as the register update
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [11:0] inj);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (awvalid && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        for (int c = 2; c <= 4; c++) evt[c] <= inj[4*(c-2) +: 3];
        bready <= 1'b1;
        do begin
            @(posedge clk);
            for (int c = 2; c <= 4; c++) evt[c] <= 3'b000;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a);
        arvalid <= 1'b1;
        araddr <= a;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge clk); while (!rvalid);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    // one-cycle strobe; returns at the edge that samples it
    task automatic pulse(input int ch, input logic [2:0] e);
        @(posedge clk);
        evt[ch] <= e;
        @(posedge clk);
        evt[ch] <= 3'b000;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        finish_test();
    end

    initial begin
        logic [31:0] exp;
        sys_rst = 1'b1;
        for (int c = 2; c <= 4; c++) evt[c] = 3'b000;
        {awvalid, wvalid, bready, arvalid, rready} = 5'b0_0000;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'h0;
        error_cnt = 0;
        n_checks = 0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        check({31'h0, irq}, 32'h0000_0000);
        axi_read(`DMAS_OFS_STATUS);
        check(rd, 32'h0000_0000);
        axi_read(`DMAS_OFS_ENABLE);
        check(rd, 32'h0000_0000);
        // every event kind on every channel, then the global clear
        for (int c = 2; c <= 4; c++) begin
            for (int t = 0; t < 3; t++) begin
                pulse(c, 3'b001 << t);
                exp = (32'h1 << (4*c)) | (32'h1 << (4*c + 1 + t));
                axi_read(`DMAS_OFS_STATUS);
                check(rd, exp);
                repeat (5) @(posedge clk);
                axi_read(`DMAS_OFS_STATUS);
                check(rd, exp);
                axi_write(`DMAS_OFS_CLEAR, 32'h0000_0000, 12'h000);
                axi_read(`DMAS_OFS_STATUS);
                check(rd, exp);
                axi_write(`DMAS_OFS_CLEAR, 32'h1 << (4*c), 12'h000);
                axi_read(`DMAS_OFS_STATUS);
                check(rd, 32'h0000_0000);
            end
        end
        // writes to the status word leave flags alone
        pulse(3, 3'b001);
        axi_write(`DMAS_OFS_STATUS, 32'hffff_ffff, 12'h000);
        check({30'h0, resp}, {30'h0, DMAS_OKAY});
        axi_read(`DMAS_OFS_STATUS);
        check(rd, 32'h0000_3000);
        // own-bit clear leaves the any flag standing
        axi_write(`DMAS_OFS_CLEAR, 32'h0000_2000, 12'h000);
        axi_read(`DMAS_OFS_STATUS);
        check(rd, 32'h0000_1000);
        axi_read(`DMAS_OFS_CLEAR);
        check(rd, 32'h0000_0000);
        axi_write(`DMAS_OFS_CLEAR, 32'h0000_1000, 12'h000);
        // set wins over a coincident clear
        pulse(4, 3'b100);
        axi_write(`DMAS_OFS_CLEAR, 32'h0008_0000, 12'h400);
        axi_read(`DMAS_OFS_STATUS);
        check(rd, 32'h0009_0000);
        axi_write(`DMAS_OFS_CLEAR, 32'h0001_0000, 12'h000);
        axi_read(`DMAS_OFS_STATUS);
        check(rd, 32'h0000_0000);
        // interrupt: enabled source raises, clear drops, masked source stays quiet
        axi_write(`DMAS_OFS_ENABLE, 32'h0000_2000, 12'h000);
        axi_read(`DMAS_OFS_ENABLE);
        check(rd, 32'h0000_2000);
        pulse(3, 3'b001);
        @(posedge clk);
        #1;
        check({31'h0, irq}, 32'h0000_0001);
        axi_write(`DMAS_OFS_CLEAR, 32'h0000_1000, 12'h000);
        @(posedge clk);
        #1;
        check({31'h0, irq}, 32'h0000_0000);
        pulse(2, 3'b010);
        repeat (2) @(posedge clk);
        #1;
        check({31'h0, irq}, 32'h0000_0000);
        axi_write(`DMAS_OFS_CLEAR, 32'h0000_0100, 12'h000);
        // unmapped word answers with a decode error
        axi_write(8'h0c, 32'hffff_ffff, 12'h000);
        check({30'h0, resp}, {30'h0, DMAS_DECERR});
        axi_read(8'h0c);
        check({30'h0, resp}, {30'h0, DMAS_DECERR});
        axi_read(`DMAS_OFS_STATUS);
        check(rd, 32'h0000_0000);
        finish_test();
    end
endmodule
